// ### clkgen_i2c_host.sv
// controller of the clock generator configuration bus: command port, bit engine, memory sequences
`timescale 1ns/100ps
// Operation
// - no bus traffic before power-down pin high
// - first transaction after power-up is dummy
// - data changes only while clock low
// - start and stop made while clock high
// - bytes are eight bits, MSB first
// - ninth clock carries acknowledge or not-acknowledge
// - last read byte not-acknowledged, then stop
// - block write: address, index, data, stop
// - block read uses repeated start, then stop
// - image needs base plus one page
// - page select then control bit six copies
// - direct SRAM write within one transaction
// - avoid back-to-back address-low accesses
// - failure flag locks device until success
module clkgen_i2c_host
	import clkgen_i2c_pkg::*;
#(
	parameter int PDN_WAIT_CYC = PDN_SETTLE_CYC,
	parameter logic [4:0] TADDR_MSB = TADDR_MSB_RST,
	parameter logic [1:0] TADDR_LSB = TADDR_LSB_RST
) (
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	// command port
	input wire logic I_CMD_VALID,
	input wire logic [1:0] I_CMD_OP,
	input wire logic [7:0] I_CMD_REG,
	input wire logic [7:0] I_CMD_LEN,
	input wire logic [3:0] I_CMD_PAGE,
	output logic O_CMD_READY,
	output logic O_CMD_REFUSED,
	output logic O_DONE,
	output logic O_ACK_ERR,
	output logic O_EE_FAIL,
	// write data stream
	input wire logic I_WR_VALID,
	input wire logic [7:0] I_WR_DATA,
	output logic O_WR_READY,
	// read data stream
	output logic O_RD_VALID,
	output logic [7:0] O_RD_DATA,
	// device pins
	output logic O_POWER_DOWN_PIN,
	input wire logic I_SCL,
	output logic O_SCL_OUT,
	output logic O_SCL_OE,
	input wire logic I_SDA,
	output logic O_SDA_OUT,
	output logic O_SDA_OE
);
	localparam int QW = $clog2(SCL_QUARTER_CYC + 1);
	localparam int PW = $clog2(PDN_WAIT_CYC + 1);

	state_t st;
	kind_t kind;
	op_t op;
	logic [1:0] pin_s;
	logic scl_s;
	logic sda_s;
	logic scl_low;
	logic sda_low;
	logic [1:0] ph;
	logic [QW-1:0] qcnt;
	logic [PW-1:0] pcnt;
	logic hold;
	logic tick;
	logic [3:0] bitn;
	logic [7:0] shift;
	logic [7:0] remain;
	logic [7:0] cmd_reg;
	logic [7:0] cmd_len;
	logic [7:0] poll_val;
	logic [3:0] page;
	logic [1:0] step;
	logic primed;
	logic dummy;
	logic rep;
	logic nack;
	logic page_done;
	logic last_low;
	logic user_op;
	logic rx_kind;
	logic tx_bit_low;
	logic refuse;
	logic accept;
	logic rd_done;
	logic poll_again;
	logic finish;
	logic [17:0] cur;
	logic cur_rd;
	logic cur_last;
	logic [7:0] cur_reg;
	logic [7:0] cur_data;

	// one bus transaction per step: {read, last step, register, write data}
	function automatic logic [17:0] step_fn(input op_t o, input logic [1:0] s, input logic [7:0] r,
		input logic [3:0] pg);
		logic [17:0] v;
		v = {2'b01, r, 8'h00};
		case (o)
			OP_READ: v = {2'b11, r, 8'h00};
			OP_PAGE: begin
				if (s == 2'h0)
					v = {2'b00, REG_PAGE_SEL, {4'h0, pg}};
				else
					v = {2'b01, REG_MEM_CTRL, MCS_PAGE_CMD};
			end
			OP_PROG: begin
				case (s)
					2'h0: v = {2'b00, REG_EE_KEY, EE_UNLOCK_KEY};
					2'h1: v = {2'b00, REG_MEM_CTRL, MCS_PROG_CMD};
					2'h2: v = {2'b10, REG_MEM_CTRL, 8'h00};
					default: v = {2'b01, REG_EE_KEY, EE_LOCK_KEY};
				endcase
			end
			default: v = {2'b01, r, 8'h00};
		endcase
		return v;
	endfunction : step_fn

	clkgen_i2c_sync #(
		.W(2),
		.RST_VAL(2'h3)
	) u_pin_sync (
		.i_clk(I_CLK_SYS),
		.i_rst(I_SYS_RST),
		.i_async({I_SCL, I_SDA}),
		.o_sync(pin_s)
	);
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	assign cur = step_fn(op, step, cmd_reg, page);
	assign cur_rd = cur[17];
	assign cur_last = cur[16];
	assign cur_reg = cur[15:8];
	assign cur_data = cur[7:0];
	assign user_op = (op == OP_WRITE) || (op == OP_READ);
	assign rx_kind = (kind == K_RDATA);
	// ninth bit: ack every read byte but the last, release for written bytes
	assign tx_bit_low = (bitn == 4'h8) ? (rx_kind && remain != 8'h00) : (!rx_kind && !shift[7]);
	assign poll_again = (op == OP_PROG) && (step == 2'h2) && poll_val[MCS_BUSY_BIT];
	assign finish = (st == ST_NEXT) && !dummy && (nack || (cur_last && !poll_again));
	assign rd_done = (st == ST_BIT) && tick && (ph == 2'h3) && (bitn == 4'h8) && rx_kind;
	assign accept = (st == ST_IDLE) && I_CMD_VALID && !refuse;

	always_comb begin
		refuse = 1'b0;
		if ((I_CMD_OP == OP_WRITE || I_CMD_OP == OP_READ) && I_CMD_LEN == 8'h00) begin
			refuse = 1'b1;
		end else if (I_CMD_OP == OP_PAGE && I_CMD_PAGE > SRAM_PAGE_MAX) begin
			refuse = 1'b1;
		end else if (I_CMD_OP == OP_PROG && !page_done) begin
			refuse = 1'b1;
		end else if (I_CMD_OP != OP_PROG && O_EE_FAIL) begin
			refuse = 1'b1;
		end else if (I_CMD_OP != OP_PAGE && I_CMD_OP != OP_PROG && I_CMD_REG == REG_MEM_ADDR_LO && last_low) begin
			refuse = 1'b1;
		end
	end

	// power the device up, then keep the bus quiet while it settles
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			O_POWER_DOWN_PIN <= 1'b0;
			pcnt <= PW'(PDN_WAIT_CYC);
		end else begin
			O_POWER_DOWN_PIN <= 1'b1;
			if (pcnt != '0)
				pcnt <= pcnt - 1'b1;
		end
	end

	// quarter-bit timer; a target holding the clock low stretches the low phase
	assign hold = !scl_low && !scl_s && (st == ST_BIT || st == ST_START || st == ST_STOP);
	assign tick = (qcnt == '0) && !hold;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || st == ST_IDLE || st == ST_LOAD || st == ST_PWRUP) begin
			qcnt <= QW'(SCL_QUARTER_CYC - 1);
		end else if (tick) begin
			qcnt <= QW'(SCL_QUARTER_CYC - 1);
		end else if (!hold) begin
			qcnt <= qcnt - 1'b1;
		end
	end

	// transaction engine
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			st <= ST_PWRUP;
			ph <= 2'h0;
			bitn <= 4'h0;
			kind <= K_ADDRW;
			shift <= 8'h00;
			remain <= 8'h00;
			op <= OP_WRITE;
			step <= 2'h0;
			cmd_reg <= 8'h00;
			cmd_len <= 8'h00;
			page <= 4'h0;
			primed <= 1'b0;
			dummy <= 1'b0;
			rep <= 1'b0;
			nack <= 1'b0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
		end else begin
			case (st)
				ST_PWRUP: begin
					if (pcnt == '0)
						st <= ST_IDLE;
				end
				ST_IDLE: begin
					ph <= 2'h0;
					if (accept) begin
						op <= op_t'(I_CMD_OP);
						cmd_reg <= I_CMD_REG;
						cmd_len <= I_CMD_LEN;
						page <= I_CMD_PAGE;
						step <= 2'h0;
						dummy <= !primed;
						rep <= 1'b0;
						nack <= 1'b0;
						st <= ST_START;
					end
				end
				ST_START: if (tick) begin
					ph <= ph + 2'h1;
					case (ph)
						2'h0: sda_low <= 1'b0;
						2'h1: scl_low <= 1'b0;
						2'h2: sda_low <= 1'b1;
						default: begin
							scl_low <= 1'b1;
							shift <= {TADDR_MSB, TADDR_LSB, rep};
							kind <= rep ? K_ADDRR : K_ADDRW;
							bitn <= 4'h0;
							st <= ST_BIT;
						end
					endcase
				end
				ST_BIT: if (tick) begin
					ph <= ph + 2'h1;
					case (ph)
						2'h0: sda_low <= tx_bit_low;
						2'h1: scl_low <= 1'b0;
						2'h3: begin
							scl_low <= 1'b1;
							if (bitn != 4'h8) begin
								shift <= {shift[6:0], sda_s};
								bitn <= bitn + 4'h1;
							end else begin
								bitn <= 4'h0;
								if (dummy) begin
									st <= ST_STOP;
								end else if (!rx_kind && sda_s) begin
									nack <= 1'b1;
									st <= ST_STOP;
								end else begin
									case (kind)
										K_ADDRW: begin
											kind <= K_REG;
											shift <= cur_reg;
										end
										K_REG: begin
											remain <= user_op ? cmd_len - 8'h01 : 8'h00;
											if (cur_rd) begin
												rep <= 1'b1;
												st <= ST_START;
											end else if (user_op) begin
												st <= ST_LOAD;
											end else begin
												kind <= K_WDATA;
												shift <= cur_data;
											end
										end
										K_WDATA: begin
											if (remain != 8'h00) begin
												remain <= remain - 8'h01;
												st <= ST_LOAD;
											end else begin
												st <= ST_STOP;
											end
										end
										K_ADDRR: kind <= K_RDATA;
										default: begin
											if (remain != 8'h00)
												remain <= remain - 8'h01;
											else
												st <= ST_STOP;
										end
									endcase
								end
							end
						end
						default: ;
					endcase
				end
				ST_LOAD: begin
					// clock stays low while the source has no byte ready
					if (I_WR_VALID) begin
						shift <= I_WR_DATA;
						kind <= K_WDATA;
						st <= ST_BIT;
					end
				end
				ST_STOP: if (tick) begin
					ph <= ph + 2'h1;
					case (ph)
						2'h0: sda_low <= 1'b1;
						2'h1: scl_low <= 1'b0;
						2'h2: sda_low <= 1'b0;
						default: st <= ST_NEXT;
					endcase
				end
				default: begin
					rep <= 1'b0;
					if (dummy) begin
						dummy <= 1'b0;
						primed <= 1'b1;
						st <= ST_START;
					end else if (nack) begin
						st <= ST_IDLE;
					end else if (poll_again) begin
						st <= ST_START;
					end else if (cur_last) begin
						st <= ST_IDLE;
					end else begin
						step <= step + 2'h1;
						st <= ST_START;
					end
				end
			endcase
		end
	end

	// read data, poll capture and status
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			O_RD_VALID <= 1'b0;
			O_RD_DATA <= 8'h00;
			poll_val <= 8'h00;
			O_DONE <= 1'b0;
			O_ACK_ERR <= 1'b0;
			O_EE_FAIL <= 1'b0;
			O_CMD_REFUSED <= 1'b0;
			page_done <= 1'b0;
			last_low <= 1'b0;
		end else begin
			O_RD_VALID <= rd_done && user_op;
			if (rd_done && user_op)
				O_RD_DATA <= shift;
			if (rd_done && !user_op)
				poll_val <= shift;
			O_DONE <= finish;
			O_CMD_REFUSED <= (st == ST_IDLE) && I_CMD_VALID && refuse;
			if (finish)
				O_ACK_ERR <= nack;
			if (finish && !nack && op == OP_PAGE)
				page_done <= 1'b1;
			if (finish && !nack && op == OP_PROG)
				O_EE_FAIL <= poll_val[MCS_FAIL_BIT];
			if (accept)
				last_low <= (I_CMD_OP == OP_WRITE || I_CMD_OP == OP_READ) && I_CMD_REG == REG_MEM_ADDR_LO;
		end
	end

	assign O_CMD_READY = (st == ST_IDLE);
	assign O_WR_READY = (st == ST_LOAD);
	// open-drain pins: only ever pull low
	assign O_SCL_OUT = 1'b0;
	assign O_SDA_OUT = 1'b0;
	assign O_SCL_OE = scl_low;
	assign O_SDA_OE = sda_low;

	property p_quiet_before_power;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(pcnt != '0) |-> (st == ST_PWRUP) && !scl_low && !sda_low;
	endproperty
	a_quiet_before_power: assert property (p_quiet_before_power) else $error("bus driven before power settle");

	property p_dummy_first;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(st == ST_BIT && !primed) |-> dummy && (kind == K_ADDRW);
	endproperty
	a_dummy_first: assert property (p_dummy_first) else $error("first transaction is not a dummy");

	property p_sda_stable_high;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(st == ST_BIT && !scl_low) |=> $stable(sda_low);
	endproperty
	a_sda_stable_high: assert property (p_sda_stable_high) else $error("data moved while clock high");

	property p_start_cond;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(st == ST_START && $rose(sda_low)) |-> !scl_low ##[1:30] scl_low;
	endproperty
	a_start_cond: assert property (p_start_cond) else $error("start not made with clock high");

	property p_stop_cond;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(st == ST_STOP && $fell(sda_low)) |-> !scl_low ##1 (!sda_low && !scl_low);
	endproperty
	a_stop_cond: assert property (p_stop_cond) else $error("stop not made with clock high");

	property p_nine_bits;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(st == ST_BIT && tick && ph == 2'h3 && bitn == 4'h8) |=> (bitn == 4'h0);
	endproperty
	a_nine_bits: assert property (p_nine_bits) else $error("byte not closed after ninth bit");

	property p_ack_level;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(st == ST_BIT && bitn == 4'h8 && ph == 2'h2) |-> (sda_low == (rx_kind && remain != 8'h00));
	endproperty
	a_ack_level: assert property (p_ack_level) else $error("wrong level on acknowledge bit");

	property p_last_read_stop;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(rd_done && remain == 8'h00) |=> (st == ST_STOP) && (ph == 2'h0);
	endproperty
	a_last_read_stop: assert property (p_last_read_stop) else $error("no stop after last read byte");

	property p_load_byte;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(st == ST_LOAD && I_WR_VALID) |=> (st == ST_BIT) && (kind == K_WDATA) && (shift == $past(I_WR_DATA));
	endproperty
	a_load_byte: assert property (p_load_byte) else $error("write byte not taken");

	property p_read_out;
		@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
		(rd_done && user_op) |=> O_RD_VALID && (O_RD_DATA == $past(shift)) ##1 !O_RD_VALID;
	endproperty
	a_read_out: assert property (p_read_out) else $error("read byte not delivered");
endmodule : clkgen_i2c_host

// ### clkgen_i2c_pkg.sv
// package: register map, key values, bus timing and encodings for the configuration bus controller
package clkgen_i2c_pkg;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_QUARTER_NS = 2500;
	localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PDN_SETTLE_US = 1000;
	localparam int PDN_SETTLE_CYC = (PDN_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// bus address of the device
	localparam logic [4:0] TADDR_MSB_RST = 5'h19;
	localparam logic [1:0] TADDR_LSB_RST = 2'h0;

	// register offsets
	localparam logic [7:0] REG_TARGET_ADDR = 8'h0a;
	localparam logic [7:0] REG_EE_COUNT = 8'h88;
	localparam logic [7:0] REG_MEM_CTRL = 8'h89;
	localparam logic [7:0] REG_MEM_ADDR_HI = 8'h8b;
	localparam logic [7:0] REG_MEM_ADDR_LO = 8'h8c;
	localparam logic [7:0] REG_SRAM_DATA = 8'h8e;
	localparam logic [7:0] REG_EE_KEY = 8'h90;
	localparam logic [7:0] REG_PAGE_SEL = 8'h91;

	// memory_control_status fields
	localparam int MCS_PROG_BIT = 0;
	localparam int MCS_BUSY_BIT = 2;
	localparam int MCS_FAIL_BIT = 5;
	localparam int MCS_PAGE_BIT = 6;
	localparam logic [7:0] MCS_PROG_CMD = 8'h01 << MCS_PROG_BIT;
	localparam logic [7:0] MCS_PAGE_CMD = 8'h01 << MCS_PAGE_BIT;

	// key values and page range
	localparam logic [7:0] EE_UNLOCK_KEY = 8'hea;
	localparam logic [7:0] EE_LOCK_KEY = 8'h00;
	localparam logic [3:0] SRAM_PAGE_MAX = 4'h5;

	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_READ = 2'h1,
		OP_PAGE = 2'h2,
		OP_PROG = 2'h3
	} op_t;

	typedef enum logic [6:0] {
		ST_PWRUP = 7'h01,
		ST_IDLE = 7'h02,
		ST_START = 7'h04,
		ST_BIT = 7'h08,
		ST_LOAD = 7'h10,
		ST_STOP = 7'h20,
		ST_NEXT = 7'h40
	} state_t;

	typedef enum logic [4:0] {
		K_ADDRW = 5'h01,
		K_REG = 5'h02,
		K_WDATA = 5'h04,
		K_ADDRR = 5'h08,
		K_RDATA = 5'h10
	} kind_t;

endpackage : clkgen_i2c_pkg

// ### clkgen_i2c_sync.sv
// two-flop synchroniser for pins that arrive from outside the system clock
`timescale 1ns/100ps
module clkgen_i2c_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// pins
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule : clkgen_i2c_sync

// ### clkgen_dev_model.sv
// behavioural model of the clock generator's configuration bus target
`timescale 1ns/100ps
module clkgen_dev_model
	import clkgen_i2c_pkg::*;
(
	// pins
	input wire logic i_pdn,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [1:0] i_strap,
	output logic o_scl_oe,
	output logic o_sda_oe,
	// fault and pace controls
	input wire logic i_fail,
	input wire logic i_slow,
	output int o_early
);
	logic [7:0] mem [0:255];
	logic [7:0] sram [0:511];
	logic [8:0] saddr;
	logic [7:0] sh, tx, idx, prog_count;
	logic [5:0] page_done;
	logic ok, fresh, busy, fail, ackd;
	logic [2:0] boot;
	int st, cnt;

	initial begin
		{o_early, st, cnt, saddr, prog_count, page_done} = '0;
		{ok, busy, fail, o_scl_oe, o_sda_oe} = '0;
		fresh = 1'b1;
	end

	function automatic logic [7:0] rd(input logic [7:0] a);
		case (a)
			REG_TARGET_ADDR: return {TADDR_MSB_RST, i_strap, 1'b0};
			REG_EE_COUNT: return prog_count;
			REG_MEM_CTRL: return {2'h0, fail, 2'h0, busy, 2'h0};
			REG_SRAM_DATA: return ok ? sram[saddr] : ~sh;
			default: return mem[a];
		endcase
	endfunction : rd

	task wr(input logic [7:0] a, input logic [7:0] d);
		if (a == REG_MEM_CTRL) begin
			if (d[MCS_PAGE_BIT] && !fail) page_done[mem[REG_PAGE_SEL][3:0]] = 1'b1;
			if (d[MCS_PROG_BIT] && mem[REG_EE_KEY] == EE_UNLOCK_KEY) busy = 1'b1;
		end else if (a == REG_MEM_ADDR_HI) saddr[8] = d[0];
		else if (a == REG_MEM_ADDR_LO) begin
			saddr[7:0] = d;
			ok = 1'b1;
		end else if (a == REG_SRAM_DATA && ok) begin
			sram[saddr] = d;
			saddr = saddr + 9'h001;
		end else if (!fail || a == REG_EE_KEY) mem[a] = d;
	endtask : wr

	task load;
		tx = rd(idx);
		if (idx == REG_SRAM_DATA && ok) saddr = saddr + 9'h001;
		if (idx == REG_MEM_CTRL && busy) begin
			busy = 1'b0;
			fail = i_fail;
			if (!i_fail) prog_count = prog_count + 8'h01;
		end
		idx = idx + 8'h01;
	endtask : load

	// power-up: first transaction ignored; start-up page pins are tied to page 0 here
	always @(posedge i_pdn) begin
		fresh = 1'b1;
		boot = 3'h0;
	end

	always @(negedge i_sda) begin
		if (i_scl === 1'b1) begin
			if (!i_pdn) o_early = o_early + 1;
			st = 1;
			cnt = 0;
			o_sda_oe = 1'b0;
		end
	end

	// a stop ends indirect memory access and the ignored first transaction
	always @(posedge i_sda) begin
		if (i_scl === 1'b1 && i_pdn) begin
			st = 0;
			cnt = 0;
			ok = 1'b0;
			fresh = 1'b0;
		end
	end

	// bits are taken 50 ns into the high phase, so shorter clock pulses count for nothing
	always @(posedge i_scl) begin
		#50;
		if (i_scl === 1'b1) begin
			if (cnt < 8) sh = {sh[6:0], i_sda};
			else ackd = i_sda;
			cnt = cnt + 1;
		end
	end

	always @(negedge i_scl) begin
		if (st != 0 && cnt == 8) begin
			o_sda_oe = 1'b0;
			case (st)
				1: begin
					if (sh[7:1] == {TADDR_MSB_RST, i_strap} && !fresh) begin
						o_sda_oe = 1'b1;
						st = sh[0] ? 4 : 2;
					end else st = 0;
				end
				2: begin
					idx = sh;
					st = 3;
					o_sda_oe = 1'b1;
				end
				3: begin
					wr(idx, sh);
					idx = idx + 8'h01;
					o_sda_oe = 1'b1;
				end
				default: ;
			endcase
		end else if (cnt == 9) begin
			cnt = 0;
			o_sda_oe = 1'b0;
			if (st == 4 && ackd) st = 0;
			else if (st == 4) begin
				load;
				o_sda_oe = !tx[7];
			end
			// slow mode stretches the clock low after every byte, past the host's own low time
			if (i_slow) begin
				o_scl_oe = 1'b1;
				#8000;
				o_scl_oe = 1'b0;
			end
		end else if (st == 4 && cnt > 0 && cnt < 8) o_sda_oe = !tx[7 - cnt];
	end
endmodule : clkgen_dev_model

// ### clkgen_i2c_host_test.sv
// self-checking testbench of the configuration bus controller
`timescale 1ns/100ps
module clkgen_i2c_host_test;
	import clkgen_i2c_pkg::*;
	logic clk, rst, valid, wr_valid, fail, slow;
	logic [1:0] op, strap;
	logic [7:0] rg, ln;
	logic [3:0] pg;
	logic [7:0] wbuf [0:7];
	logic [7:0] rbuf [0:7];
	int wi, rn, dn, rf, miscompares, checks, early, i;
	wire logic ready, refused, done, ack_err, ee_fail, wr_ready, rd_valid, power_down_pin;
	wire logic scl_oe, sda_oe, d_scl_oe, d_sda_oe;
	wire logic [7:0] rd_data;
	wire logic [7:0] wr_data = wbuf[wi[2:0]];
	// open-drain wires with pull-ups
	wire logic scl = !(scl_oe || d_scl_oe);
	wire logic sda = !(sda_oe || d_sda_oe);

	clkgen_i2c_host #(.PDN_WAIT_CYC(20)) clkgen_i2c_host_inst (.I_CLK_SYS(clk), .I_SYS_RST(rst),
		.I_CMD_VALID(valid), .I_CMD_OP(op), .I_CMD_REG(rg), .I_CMD_LEN(ln), .I_CMD_PAGE(pg),
		.O_CMD_READY(ready), .O_CMD_REFUSED(refused), .O_DONE(done), .O_ACK_ERR(ack_err),
		.O_EE_FAIL(ee_fail), .I_WR_VALID(wr_valid), .I_WR_DATA(wr_data), .O_WR_READY(wr_ready),
		.O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_POWER_DOWN_PIN(power_down_pin), .I_SCL(scl),
		.O_SCL_OUT(), .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA_OUT(), .O_SDA_OE(sda_oe));

	clkgen_dev_model clkgen_dev_model_inst (.i_pdn(power_down_pin), .i_scl(scl), .i_sda(sda), .i_strap(strap),
		.o_scl_oe(d_scl_oe), .o_sda_oe(d_sda_oe), .i_fail(fail), .i_slow(slow), .o_early(early));

	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_byte

	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// one command, then wait for its finish or refusal
	task automatic run(input logic [1:0] o, input logic [7:0] r, input logic [7:0] l, input logic [3:0] p);
		int d0, r0, n;
		d0 = dn;
		r0 = rf;
		n = 0;
		@(negedge clk);
		{op, rg, ln, pg} = {o, r, l, p};
		wi = 0;
		rn = 0;
		valid = 1'b1;
		wr_valid = 1'b1;
		@(negedge clk);
		valid = 1'b0;
		while (dn == d0 && rf == r0 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		// a command that never finishes is a mismatch, not a silent skip
		if (n >= 40000) miscompares++;
		wr_valid = 1'b0;
	endtask : run

	always @(posedge clk) begin
		if (wr_ready === 1'b1 && wr_valid === 1'b1) wi <= wi + 1;
		if (rd_valid === 1'b1) begin
			rbuf[rn[2:0]] <= rd_data;
			rn <= rn + 1;
		end
		if (done === 1'b1) dn <= dn + 1;
		if (refused === 1'b1) rf <= rf + 1;
	end

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// about 84k cycles of traffic are expected
	initial begin
		repeat (95000) @(posedge clk);
		miscompares++;
		end_of_test;
	end

	initial begin
		{rst, valid, wr_valid, op, rg, ln, pg, strap, fail, slow} = {1'b1, 28'h0};
		{wi, rn, dn, rf, miscompares, checks} = '0;
		for (i = 0; i < 8; i++) wbuf[i] = 8'(i * 8'h35 + 8'h1c);
		repeat (6) @(negedge clk);
		chk_bit("power pin in reset", 1'b0, power_down_pin);
		rst = 1'b0;
		repeat (26) @(negedge clk);
		chk_bit("power pin", 1'b1, power_down_pin);
		run(OP_WRITE, 8'h0b, 8'h03, 4'h0);
		chk_bit("write ack error", 1'b0, ack_err);
		slow = 1'b1;
		run(OP_READ, REG_TARGET_ADDR, 8'h04, 4'h0);
		slow = 1'b0;
		chk_byte("read count", 8'h04, rn[7:0]);
		chk_byte("address readback", {TADDR_MSB_RST, TADDR_LSB_RST, 1'b0}, rbuf[0]);
		for (i = 1; i < 4; i++) chk_byte("block read", 8'(i * 8'h35 - 8'h19), rbuf[i]);
		strap = 2'h1;
		run(OP_WRITE, 8'h20, 8'h01, 4'h0);
		chk_bit("foreign address", 1'b1, ack_err);
		strap = 2'h0;
		{wbuf[0], wbuf[1], wbuf[2], wbuf[3]} = 32'h000b00c5;
		run(OP_WRITE, REG_MEM_ADDR_HI, 8'h04, 4'h0);
		chk_byte("sram byte", 8'hc5, clkgen_dev_model_inst.sram[9'h00b]);
		run(OP_WRITE, REG_MEM_ADDR_LO, 8'h01, 4'h0);
		run(OP_WRITE, REG_MEM_ADDR_LO, 8'h01, 4'h0);
		chk_byte("refusals", 8'h01, rf[7:0]);
		run(OP_WRITE, 8'h20, 8'h00, 4'h0);
		run(OP_PAGE, 8'h00, 8'h01, 4'h6);
		run(OP_PROG, 8'h00, 8'h01, 4'h0);
		chk_byte("refusals", 8'h04, rf[7:0]);
		chk_bit("ready after refusal", 1'b1, ready);
		run(OP_PAGE, 8'h00, 8'h01, SRAM_PAGE_MAX);
		chk_bit("page copied", 1'b1, clkgen_dev_model_inst.page_done[5]);
		run(OP_PROG, 8'h00, 8'h01, 4'h0);
		chk_bit("program fail", 1'b0, ee_fail);
		chk_byte("key relocked", EE_LOCK_KEY, clkgen_dev_model_inst.mem[REG_EE_KEY]);
		fail = 1'b1;
		run(OP_PROG, 8'h00, 8'h01, 4'h0);
		fail = 1'b0;
		chk_bit("program fail", 1'b1, ee_fail);
		run(OP_WRITE, 8'h20, 8'h01, 4'h0);
		chk_byte("refusals", 8'h05, rf[7:0]);
		run(OP_PROG, 8'h00, 8'h01, 4'h0);
		chk_bit("program recovered", 1'b0, ee_fail);
		run(OP_READ, REG_EE_COUNT, 8'h01, 4'h0);
		chk_byte("program count", 8'h02, rbuf[0]);
		chk_byte("early starts", 8'h00, early[7:0]);
		end_of_test;
	end
endmodule : clkgen_i2c_host_test
